// File: logic/drc_pkg.sv
// drc_pkg: shared constants for the dual converter reference control block
// assumes: 8-bit register port, byte-addressed offsets as printed
package drc_pkg;
  // ==========================================================================
  // register offsets
  localparam logic [15:0] CONV1_CONTROL_OFS = 16'h088c;  // converter1_control
  localparam logic [15:0] CONV1_CODE_OFS    = 16'h088d;  // converter1_code
  localparam logic [15:0] CONV2_CONTROL_OFS = 16'h0890;  // converter2_control
  localparam logic [15:0] CONV2_CODE_OFS    = 16'h0891;  // converter2_code
  // ==========================================================================
  // control field positions
  localparam int EN_BIT      = 7;   // enable
  localparam int RNG_BIT     = 6;   // buffer_range_select
  localparam int OE_HI       = 5;   // output enable msb
  localparam int OE_LO       = 4;   // output enable lsb
  localparam int PSS_HI      = 3;   // positive_reference_select msb
  localparam int PSS_LO      = 2;   // positive_reference_select lsb
  localparam int NSS_BIT     = 0;   // negative_reference_select
  // writable masks: unimplemented bits stay zero
  localparam logic [7:0] CONV1_CTRL_MASK = 8'h0fd;
  localparam logic [7:0] CONV2_CTRL_MASK = 8'h08d;
  localparam logic [7:0] REG_RESET       = 8'h00;
  // ==========================================================================
  // field encodings
  localparam logic [1:0] OE_PIN_ONE = 2'h1;  // first pin only
  localparam logic [1:0] OE_PIN_TWO = 2'h2;  // second pin only
  localparam logic [1:0] PSS_SUPPLY = 2'h0;  // supply rail
  localparam logic [1:0] PSS_EXTREF = 2'h1;  // external positive reference
  localparam logic [1:0] PSS_FIXED  = 2'h2;  // fixed_reference_buffer two
  // auto-range threshold: codes at or above pick the high range
  localparam logic [7:0] AUTO_RANGE_THRESHOLD = 8'h80;
  // reset synchroniser length
  localparam int RST_SYNC_STAGES = 2;
endpackage

// File: logic/drc_conv_chan.sv
// drc_conv_chan: one converter instance, control and code decode to analog controls
// assumes: registers supplied by the top, same clock, no pin inputs
`timescale 1ns/1ps
module drc_conv_chan #(
  parameter bit HAS_BUFFER = 1'b1      // first instance has buffer and pins
) (
  input  wire logic [7:0] ctrl,        // control register value
  input  wire logic [7:0] code,        // code register value
  input  wire logic       sleep_mode,  // device asleep
  output logic            conv_on,     // ladder powered
  output logic [1:0]      pos_sel,     // positive reference choice
  output logic            neg_sel,     // negative reference choice
  output logic [7:0]      level,       // ladder tap code
  output logic [1:0]      pin_drive    // pin drive, at most one bit set
);
  // ==========================================================================
  // decode
  always_comb begin
    // enable gates operation; sleep also powers down
    conv_on   = ctrl[drc_pkg::EN_BIT] & ~sleep_mode;
    pos_sel   = ctrl[drc_pkg::PSS_HI:drc_pkg::PSS_LO];
    neg_sel   = ctrl[drc_pkg::NSS_BIT];
    level     = code;
    pin_drive = 2'h0;
    // second instance never reaches a pin
    if (HAS_BUFFER && conv_on) begin
      case (ctrl[drc_pkg::OE_HI:drc_pkg::OE_LO])
        drc_pkg::OE_PIN_ONE: pin_drive = 2'h1;
        drc_pkg::OE_PIN_TWO: pin_drive = 2'h2;
        default:             pin_drive = 2'h0;
      endcase
    end
  end
endmodule

// File: logic/drc_range_sel.sv
// drc_range_sel: buffer range choice for the first instance
// assumes: config bit static after reset
`timescale 1ns/1ps
module drc_range_sel (
  input  wire logic       auto_range_config_bit, // 1 = software range
  input  wire logic       sw_range,              // software range bit
  input  wire logic [7:0] code,                  // current output code
  output logic            high_range             // 1 = high range
);
  // ==========================================================================
  // selection
  always_comb begin
    if (auto_range_config_bit) begin
      high_range = sw_range;
    end else begin
      high_range = (code >= drc_pkg::AUTO_RANGE_THRESHOLD);
    end
  end
endmodule

// File: logic/drc_top.sv
// drc_top: register file and control of two 8-bit converter instances
// assumes: single clock, simple strobe register port, config bit from fuses
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
// Contract
// - enable bit seven runs each instance
// - second instance internal only, no pins
// - output enable 01 pin one, 10 pin two
// - pin enables never both set
// - positive reference select bits three two
// - negative reference select bit zero
// - eight-bit code sets output level
// - config set: software range bit used
// - config clear: hardware range from code
// - range affects only first buffered output
// - registers kept through sleep, reference off
// - reset disables, removes pins, clears code
// - second control only enable and references
module drc_top (
  input  wire logic        clk,                   // system clock
  input  wire logic        nrst,                  // async reset, active low
  input  wire logic        clk_en,                // freezes all state but the reset synchroniser when low
  input  wire logic [15:0] addr,                  // register address
  input  wire logic [7:0]  wdata,                 // write data
  input  wire logic        wr,                    // write strobe
  input  wire logic        rd,                    // read strobe
  output logic [7:0]       rdata,                 // read data, cycle after rd
  input  wire logic        auto_range_config_bit, // configuration word bit
  input  wire logic        sleep_mode,            // device in sleep
  output logic             conv1_on,              // first ladder on
  output logic [1:0]       conv1_pos_sel,         // first positive ref
  output logic             conv1_neg_sel,         // first negative ref
  output logic [7:0]       conv1_level,           // first code
  output logic             conv1_high_range,      // buffer range
  output logic             buffered_output_pin_one, // drive pin one
  output logic             buffered_output_pin_two, // drive pin two
  output logic             conv2_on,              // second ladder on
  output logic [1:0]       conv2_pos_sel,         // second positive ref
  output logic             conv2_neg_sel,         // second negative ref
  output logic [7:0]       conv2_level            // second code
);
  // ==========================================================================
  // reset synchroniser
  logic [1:0] rst_sync_reg;  // stage 0 feeds stage 1 only
  logic       rst_n;         // synchronised reset

  // async assert, synchronous release
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // ==========================================================================
  // config bit and sleep synchronisers (config arrives from the fuse domain)
  logic [1:0] cfg_sync_reg;  // two stages
  logic [1:0] slp_sync_reg;  // sleep level, two stages

  // two flops before any use
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_sync_reg <= 2'h0;
      slp_sync_reg <= 2'h0;
    end else if (clk_en) begin
      cfg_sync_reg <= {cfg_sync_reg[0], auto_range_config_bit};
      slp_sync_reg <= {slp_sync_reg[0], sleep_mode};
    end
  end

  // ==========================================================================
  // registers
  logic [7:0] conv1_control_reg;  // first instance control
  logic [7:0] conv1_code_reg;     // first instance code
  logic [7:0] conv2_control_reg;  // second instance control
  logic [7:0] conv2_code_reg;     // second instance code

  // write decode; values survive sleep since only reset clears them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conv1_control_reg <= drc_pkg::REG_RESET;
      conv1_code_reg    <= drc_pkg::REG_RESET;
      conv2_control_reg <= drc_pkg::REG_RESET;
      conv2_code_reg    <= drc_pkg::REG_RESET;
    end else if (clk_en && wr) begin
      // no sleep term here, contents kept
      case (addr)
        drc_pkg::CONV1_CONTROL_OFS: begin
          conv1_control_reg <= wdata & drc_pkg::CONV1_CTRL_MASK;
        end
        drc_pkg::CONV1_CODE_OFS: begin
          conv1_code_reg <= wdata;
        end
        drc_pkg::CONV2_CONTROL_OFS: begin
          conv2_control_reg <= wdata & drc_pkg::CONV2_CTRL_MASK;
        end
        drc_pkg::CONV2_CODE_OFS: begin
          conv2_code_reg <= wdata;
        end
        default: begin
          // unmapped writes dropped
        end
      endcase
    end
  end

  // ==========================================================================
  // read port: data in the cycle after rd only
  // read mux
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (clk_en) begin
      if (rd) begin
        case (addr)
          drc_pkg::CONV1_CONTROL_OFS: rdata <= conv1_control_reg;
          drc_pkg::CONV1_CODE_OFS:    rdata <= conv1_code_reg;
          drc_pkg::CONV2_CONTROL_OFS: rdata <= conv2_control_reg;
          drc_pkg::CONV2_CODE_OFS:    rdata <= conv2_code_reg;
          default:                    rdata <= 8'h00;  // unmapped reads zero
        endcase
      end else begin
        rdata <= 8'h00;
      end
    end
  end

  // ==========================================================================
  // instances
  logic [1:0] pin1_drive;  // first instance pins
  logic       c1_on;       // first instance on
  logic [1:0] c1_pss;      // first positive ref
  logic       c1_nss;      // first negative ref
  logic [7:0] c1_lvl;      // first level
  logic       c2_on;       // second instance on
  logic [1:0] c2_pss;      // second positive ref
  logic       c2_nss;      // second negative ref
  logic [7:0] c2_lvl;      // second level
  logic       hi_rng;      // range choice

  drc_conv_chan #(
    .HAS_BUFFER (1'b1)
  ) u_conv1 (
    .ctrl       (conv1_control_reg),
    .code       (conv1_code_reg),
    .sleep_mode (slp_sync_reg[1]),
    .conv_on    (c1_on),
    .pos_sel    (c1_pss),
    .neg_sel    (c1_nss),
    .level      (c1_lvl),
    .pin_drive  (pin1_drive)
  );

  // second instance built without buffer or pins
  drc_conv_chan #(
    .HAS_BUFFER (1'b0)
  ) u_conv2 (
    .ctrl       (conv2_control_reg),
    .code       (conv2_code_reg),
    .sleep_mode (slp_sync_reg[1]),
    .conv_on    (c2_on),
    .pos_sel    (c2_pss),
    .neg_sel    (c2_nss),
    .level      (c2_lvl),
    .pin_drive  ()
  );

  // range only for the first buffer
  drc_range_sel u_range (
    .auto_range_config_bit (cfg_sync_reg[1]),
    .sw_range              (conv1_control_reg[drc_pkg::RNG_BIT]),
    .code                  (conv1_code_reg),
    .high_range            (hi_rng)
  );

  // ==========================================================================
  // output flops: analog controls come from registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conv1_on                <= 1'b0;
      conv1_pos_sel           <= 2'h0;
      conv1_neg_sel           <= 1'b0;
      conv1_level             <= 8'h00;
      conv1_high_range        <= 1'b0;
      buffered_output_pin_one <= 1'b0;
      buffered_output_pin_two <= 1'b0;
      conv2_on                <= 1'b0;
      conv2_pos_sel           <= 2'h0;
      conv2_neg_sel           <= 1'b0;
      conv2_level             <= 8'h00;
    end else if (clk_en) begin
      // on only when enabled and awake
      conv1_on                <= c1_on;
      conv2_on                <= c2_on;
      conv1_pos_sel           <= c1_pss;
      conv1_neg_sel           <= c1_nss;
      conv2_pos_sel           <= c2_pss;
      conv2_neg_sel           <= c2_nss;
      conv1_level             <= c1_lvl;
      conv2_level             <= c2_lvl;
      conv1_high_range        <= hi_rng;
      buffered_output_pin_one <= pin1_drive[0];
      buffered_output_pin_two <= pin1_drive[1];
    end
  end
endmodule

// File: testbench/drc_top_props.sv
// drc_top_props: port-level checks for drc_top
// assumes: clk_en held high, bound from tb
`timescale 1ns/1ps
module drc_top_props (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic [15:0] addr,
  input wire logic [7:0]  wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [7:0]  rdata,
  input wire logic        auto_range_config_bit,
  input wire logic        sleep_mode,
  input wire logic        conv1_on,
  input wire logic        conv2_on,
  input wire logic [7:0]  conv1_level,
  input wire logic [7:0]  conv2_level,
  input wire logic [1:0]  conv2_pos_sel,
  input wire logic        conv2_neg_sel,
  input wire logic        conv1_high_range,
  input wire logic        buffered_output_pin_one,
  input wire logic        buffered_output_pin_two
);
  // ==========================================================================
  // one domain, so clock and reset are given once
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_one_hot; !(buffered_output_pin_one && buffered_output_pin_two); endproperty
  a_one_hot: assert property (p_one_hot) else $error("both pins driven");
  property p_pin_on; buffered_output_pin_one || buffered_output_pin_two |-> conv1_on; endproperty
  a_pin_on: assert property (p_pin_on) else $error("pin driven while off");
  property p_code1; wr && addr == drc_pkg::CONV1_CODE_OFS |-> ##2 conv1_level == $past(wdata, 2);
  endproperty
  a_code1: assert property (p_code1) else $error("first level wrong");
  property p_code2; wr && addr == drc_pkg::CONV2_CODE_OFS |-> ##2 conv2_level == $past(wdata, 2);
  endproperty
  a_code2: assert property (p_code2) else $error("second level wrong");
  property p_ref2; wr && addr == drc_pkg::CONV2_CONTROL_OFS |-> ##2
    conv2_pos_sel == $past(wdata[3:2], 2) && conv2_neg_sel == $past(wdata[0], 2); endproperty
  a_ref2: assert property (p_ref2) else $error("second refs wrong");
  property p_rd1; rd && addr == drc_pkg::CONV1_CONTROL_OFS |=> rdata[1] == 1'b0; endproperty
  a_rd1: assert property (p_rd1) else $error("unused bit reads one");
  property p_rd2; rd && addr == drc_pkg::CONV2_CONTROL_OFS |=>
    (rdata & ~drc_pkg::CONV2_CTRL_MASK) == 8'h00; endproperty
  a_rd2: assert property (p_rd2) else $error("second control extra bits");
  property p_sleep; sleep_mode [*4] |=> !conv1_on && !conv2_on; endproperty
  a_sleep: assert property (p_sleep) else $error("on while asleep");
  property p_auto; (!auto_range_config_bit && $stable(conv1_level)) [*4] |->
    conv1_high_range == (conv1_level >= drc_pkg::AUTO_RANGE_THRESHOLD); endproperty
  a_auto: assert property (p_auto) else $error("auto range wrong");
  property p_manual; auto_range_config_bit [*4] ##0 (wr && addr == drc_pkg::CONV1_CONTROL_OFS)
    |-> ##2 conv1_high_range == $past(wdata[6], 2); endproperty
  a_manual: assert property (p_manual) else $error("manual range wrong");
endmodule

// File: testbench/tb.sv
// tb: random and corner stimulus for drc_top, shadow model of the registers
// assumes: clk_en tied high, checker bound below
`timescale 1ns/1ps
bind drc_top drc_top_props u_props (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .auto_range_config_bit(auto_range_config_bit),
  .sleep_mode(sleep_mode), .conv1_on(conv1_on), .conv2_on(conv2_on),
  .conv1_level(conv1_level), .conv2_level(conv2_level), .conv2_pos_sel(conv2_pos_sel),
  .conv2_neg_sel(conv2_neg_sel), .conv1_high_range(conv1_high_range),
  .buffered_output_pin_one(buffered_output_pin_one),
  .buffered_output_pin_two(buffered_output_pin_two));
module tb;
  logic        clk, nrst, clk_en, wr, rd, cfg, slp, on1, on2, ns1, ns2, hr, p1, p2;
  logic [15:0] addr;
  logic [7:0]  wdata, rdata, l1, l2;
  logic [1:0]  ps1, ps2;
  logic [7:0]  shadow [4];   // ctrl1, code1, ctrl2, code2
  logic [15:0] ofs [5];      // last entry is an unmapped hole
  int          bad_count, cmp_count, cyc;
  drc_top dut (.clk(clk), .nrst(nrst), .clk_en(clk_en), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .auto_range_config_bit(cfg), .sleep_mode(slp), .conv1_on(on1),
    .conv1_pos_sel(ps1), .conv1_neg_sel(ns1), .conv1_level(l1), .conv1_high_range(hr),
    .buffered_output_pin_one(p1), .buffered_output_pin_two(p2), .conv2_on(on2),
    .conv2_pos_sel(ps2), .conv2_neg_sel(ns2), .conv2_level(l2));
  // ==========================================================================
  // clock, 8 ns period
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // hang guard, well above the expected run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      wrap_up();
    end
  end
  // ==========================================================================
  // helpers
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input int i, input logic [7:0] d);
    @(posedge clk);
    addr <= ofs[i];
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    // control bits outside the mask never stick
    if (i < 4) shadow[i] = d & (i == 0 ? drc_pkg::CONV1_CTRL_MASK :
      i == 2 ? drc_pkg::CONV2_CTRL_MASK : 8'hff);
  endtask
  task automatic rreg(input int i);
    @(posedge clk);
    addr <= ofs[i];
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(rdata, i < 4 ? shadow[i] : 8'h00);
  endtask
  // settle past the input syncs, then compare every output but rdata
  task automatic outs();
    logic [7:0] c1, c2;
    logic       en1;
    repeat (4) @(posedge clk);
    #1;
    c1 = shadow[0];
    c2 = shadow[2];
    en1 = c1[7] & ~slp;
    check({6'h00, on2, on1}, {6'h00, c2[7] & ~slp, en1});
    check({4'h0, ps1, 1'b0, ns1}, {4'h0, c1[3:2], 1'b0, c1[0]});
    check({4'h0, ps2, 1'b0, ns2}, {4'h0, c2[3:2], 1'b0, c2[0]});
    check(l1, shadow[1]);
    check(l2, shadow[3]);
    check({6'h00, p2, p1}, {6'h00, en1 && c1[5:4] == 2'h2, en1 && c1[5:4] == 2'h1});
    check({7'h00, hr}, {7'h00, cfg ? c1[6] : shadow[1] >= drc_pkg::AUTO_RANGE_THRESHOLD});
  endtask
  task automatic do_reset();
    #2 nrst = 1'b0;
    shadow = '{default: 8'h00};
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  task automatic wrap_up();
    if (bad_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ==========================================================================
  // main sequence
  initial begin
    ofs = '{drc_pkg::CONV1_CONTROL_OFS, drc_pkg::CONV1_CODE_OFS, drc_pkg::CONV2_CONTROL_OFS,
      drc_pkg::CONV2_CODE_OFS, 16'h088e};
    {nrst, wr, rd, slp, addr, wdata, bad_count, cmp_count, cyc} = '0;
    clk_en = 1'b1;
    cfg = 1'b1;
    void'($urandom(72599));
    do_reset();
    // reset values and masks
    for (int i = 0; i < 5; i++) rreg(i);
    for (int i = 0; i < 5; i++) begin
      wreg(i, 8'hff);
      rreg(i);
    end
    // every enable route and reference choice, first negative reference held at one
    for (int i = 0; i < 16; i++) begin
      wreg(0, {2'h2, i[3:0], 2'h1});
      wreg(2, {6'h20 | {4'h0, i[1:0]}, 2'h0} | {7'h00, i[2]});
      outs();
    end
    // auto range boundary, then manual with code still 8'h80
    // config bit clear picks auto ranging
    cfg <= 1'b0;
    wreg(1, 8'h7f);
    outs();
    wreg(1, 8'h80);
    outs();
    cfg <= 1'b1;
    wreg(0, 8'hc0);
    outs();
    // sleep keeps registers, drops drive
    slp <= 1'b1;
    wreg(0, 8'h90);
    outs();
    rreg(0);
    slp <= 1'b0;
    outs();
    // random traffic with mode flips
    for (int n = 0; n < 80; n++) begin
      cfg <= 1'($urandom_range(1, 0));
      slp <= ($urandom_range(7, 0) == 0);
      wreg($urandom_range(4, 0), 8'($urandom));
      rreg($urandom_range(4, 0));
      outs();
    end
    // reset in mid-run clears everything
    do_reset();
    for (int i = 0; i < 4; i++) rreg(i);
    outs();
    wrap_up();
  end
endmodule
